// file: hdl/efm_monitor.v
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "efm_consts.vh"

module efm_monitor #(
    parameter [21:0] FAST_CYCLES = (`EFM_FAST_US * `EFM_CLK_KHZ) / 1000
) (
    // Clock, reset, enable
    input  wire        clock,
    input  wire        rst_n,
    input  wire        ce,
    // AXI4-Lite write address
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Receive framer status
    input  wire        fas_error_pulse,
    input  wire        receive_sync_lost,
    input  wire        align_search,
    // Shared bits of the other counters
    input  wire [1:0]  crc4_count_msbs,
    input  wire [1:0]  ebit_count_msbs,
    // Transmit stream
    input  wire        tx_bit_strobe,
    input  wire        tx_frame_start,
    input  wire        tx_ser_data,
    // Receive stream
    input  wire        rx_bit_strobe,
    input  wire        rx_frame_start,
    input  wire        rx_ser_data
);

    // Decode of a byte address to a register code
    function [2:0] reg_sel;
        input [11:0] addr;
        begin
            if (addr[1:0] != 2'b00) begin
                reg_sel = `EFM_SEL_NONE;
            end else if (addr[11:2] == {2'b00, `EFM_IDX_ERR_UPPER}) begin
                reg_sel = `EFM_SEL_ERR_UPPER;
            end else if (addr[11:2] == {2'b00, `EFM_IDX_ERR_LOWER}) begin
                reg_sel = `EFM_SEL_ERR_LOWER;
            end else if (addr[11:2] == {2'b00, `EFM_IDX_TX_CTRL}) begin
                reg_sel = `EFM_SEL_TX_CTRL;
            end else if (addr[11:2] == {2'b00, `EFM_IDX_TX_SNAP}) begin
                reg_sel = `EFM_SEL_TX_SNAP;
            end else if (addr[11:2] == {2'b00, `EFM_IDX_RX_CTRL}) begin
                reg_sel = `EFM_SEL_RX_CTRL;
            end else if (addr[11:2] == {2'b00, `EFM_IDX_RX_SNAP}) begin
                reg_sel = `EFM_SEL_RX_SNAP;
            end else if (addr[11:2] == {2'b00, `EFM_IDX_INTERVAL_CTRL}) begin
                reg_sel = `EFM_SEL_INTERVAL_CTRL;
            end else begin
                reg_sel = `EFM_SEL_NONE;
            end
        end
    endfunction

    // Control registers
    reg  [7:0]  tx_ctrl_q;
    reg  [7:0]  rx_ctrl_q;
    reg  [7:0]  interval_ctrl_q;

    // Write channel state
    reg         aw_got_q;
    reg         w_got_q;
    reg  [11:0] aw_addr_q;
    reg  [7:0]  w_byte_q;
    reg         w_lane0_q;
    wire [2:0]  wr_sel;

    // Error counter state
    reg  [11:0] run_count_q;
    reg  [11:0] shown_count_q;
    reg  [21:0] cyc_q;
    reg  [3:0]  fast_cnt_q;
    wire        count_ok;
    wire        fast_tick;
    wire        boundary;
    wire [11:0] run_count_inc;

    // Channel taps
    wire [1:0]  tap_strobe;
    wire [1:0]  tap_start;
    wire [1:0]  tap_data;
    wire [9:0]  tap_sel;
    wire [15:0] tap_snap;
    reg  [7:0]  rd_byte;

    assign wr_sel = reg_sel(aw_addr_q);

    // Interval timer
    assign fast_tick = (cyc_q == (FAST_CYCLES - 22'h000001));
    assign boundary  = fast_tick &&
                       (interval_ctrl_q[`EFM_INTERVAL_FAST_BIT] ||
                        (fast_cnt_q == `EFM_FAST_PER_SEC));

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cyc_q      <= 22'h000000;
            fast_cnt_q <= 4'h0;
        end else if (ce) begin
            if (fast_tick) begin
                cyc_q      <= 22'h000000;
                fast_cnt_q <= fast_cnt_q + 4'h1;
            end else begin
                cyc_q <= cyc_q + 22'h000001;
            end
        end
    end

    // Error counter
    assign count_ok      = fas_error_pulse && !receive_sync_lost
                           && !align_search;
    assign run_count_inc = run_count_q + {11'h000, count_ok};

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            run_count_q   <= `EFM_COUNT_RESET;
            shown_count_q <= `EFM_COUNT_RESET;
        end else if (ce) begin
            if (boundary) begin
                shown_count_q <= run_count_inc;
                run_count_q   <= `EFM_COUNT_RESET;
            end else begin
                run_count_q <= run_count_inc;
            end
        end
    end

    // Transmit is index 0, receive is index 1
    assign tap_strobe = {rx_bit_strobe, tx_bit_strobe};
    assign tap_start  = {rx_frame_start, tx_frame_start};
    assign tap_data   = {rx_ser_data, tx_ser_data};
    assign tap_sel    = {rx_ctrl_q[`EFM_SEL_MSB:`EFM_SEL_LSB],
                         tx_ctrl_q[`EFM_SEL_MSB:`EFM_SEL_LSB]};

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_tap
            efm_slot_tap u_tap (
                .clock       (clock),
                .rst_n       (rst_n),
                .ce          (ce),
                .bit_strobe  (tap_strobe[g]),
                .frame_start (tap_start[g]),
                .ser_data    (tap_data[g]),
                .slot_sel    (tap_sel[g*5 +: 5]),
                .snap_q      (tap_snap[g*8 +: 8])
            );
        end
    endgenerate

    // Read data selection
    always @* begin
        rd_byte = 8'h00;
        case (reg_sel(s_axi_araddr))
            `EFM_SEL_ERR_UPPER: begin
                rd_byte = {shown_count_q[11:6], crc4_count_msbs};
            end
            `EFM_SEL_ERR_LOWER: begin
                rd_byte = {shown_count_q[5:0], ebit_count_msbs};
            end
            `EFM_SEL_TX_CTRL: begin
                rd_byte = tx_ctrl_q;
            end
            `EFM_SEL_TX_SNAP: begin
                rd_byte = tap_snap[7:0];
            end
            `EFM_SEL_RX_CTRL: begin
                rd_byte = rx_ctrl_q;
            end
            `EFM_SEL_RX_SNAP: begin
                rd_byte = tap_snap[15:8];
            end
            `EFM_SEL_INTERVAL_CTRL: begin
                rd_byte = interval_ctrl_q;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // Write path
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready   <= 1'b0;
            s_axi_wready    <= 1'b0;
            s_axi_bvalid    <= 1'b0;
            s_axi_bresp     <= `EFM_RESP_OKAY;
            aw_got_q        <= 1'b0;
            w_got_q         <= 1'b0;
            aw_addr_q       <= 12'h000;
            w_byte_q        <= 8'h00;
            w_lane0_q       <= 1'b0;
            tx_ctrl_q       <= `EFM_CTRL_RESET;
            rx_ctrl_q       <= `EFM_CTRL_RESET;
            interval_ctrl_q <= `EFM_INTERVAL_RESET;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q      <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_got_q && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q      <= 1'b1;
                w_byte_q     <= s_axi_wdata[7:0];
                w_lane0_q    <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end else if (!w_got_q && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (aw_got_q && w_got_q && !s_axi_bvalid) begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_sel == `EFM_SEL_NONE) begin
                    s_axi_bresp <= `EFM_RESP_SLVERR;
                end else begin
                    s_axi_bresp <= `EFM_RESP_OKAY;
                end
                if (w_lane0_q) begin
                    if (wr_sel == `EFM_SEL_TX_CTRL) begin
                        tx_ctrl_q <= w_byte_q;
                    end else if (wr_sel == `EFM_SEL_RX_CTRL) begin
                        rx_ctrl_q <= w_byte_q;
                    end else if (wr_sel == `EFM_SEL_INTERVAL_CTRL) begin
                        interval_ctrl_q <= {7'h00, w_byte_q[`EFM_INTERVAL_FAST_BIT]};
                    end
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read path
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `EFM_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h000000, rd_byte};
                if (reg_sel(s_axi_araddr) == `EFM_SEL_NONE) begin
                    s_axi_rresp <= `EFM_RESP_SLVERR;
                end else begin
                    s_axi_rresp <= `EFM_RESP_OKAY;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // efm_monitor

`default_nettype wire

// file: hdl/efm_consts.vh
`ifndef EFM_CONSTS_VH
`define EFM_CONSTS_VH

// Register indices; the byte address is four times the index
`define EFM_IDX_ERR_UPPER       8'h02
`define EFM_IDX_ERR_LOWER       8'h04
`define EFM_IDX_TX_CTRL         8'ha8
`define EFM_IDX_TX_SNAP         8'ha9
`define EFM_IDX_RX_CTRL         8'haa
`define EFM_IDX_RX_SNAP         8'hab
`define EFM_IDX_INTERVAL_CTRL   8'hac

// Register decode codes
`define EFM_SEL_NONE            3'h0
`define EFM_SEL_ERR_UPPER       3'h1
`define EFM_SEL_ERR_LOWER       3'h2
`define EFM_SEL_TX_CTRL         3'h3
`define EFM_SEL_TX_SNAP         3'h4
`define EFM_SEL_RX_CTRL         3'h5
`define EFM_SEL_RX_SNAP         3'h6
`define EFM_SEL_INTERVAL_CTRL   3'h7

// Field positions
`define EFM_SEL_MSB             4
`define EFM_SEL_LSB             0
`define EFM_CNT_FIELD_MSB       7
`define EFM_CNT_FIELD_LSB       2
`define EFM_INTERVAL_FAST_BIT   0

// Reset values
`define EFM_CTRL_RESET          8'h00
`define EFM_INTERVAL_RESET      8'h00
`define EFM_COUNT_RESET         12'h000

// AXI responses
`define EFM_RESP_OKAY           2'b00
`define EFM_RESP_SLVERR         2'b10

// Timing
`define EFM_CLK_KHZ             50000
`define EFM_FAST_US             62500
`define EFM_FAST_PER_SEC        4'hf
`define EFM_FRAME_BITS_LAST     3'h7

`endif

// file: hdl/efm_slot_tap.v
`timescale 1ns/1ps
`default_nettype none
`include "efm_consts.vh"

module efm_slot_tap (
    // Clock, reset, enable
    input  wire       clock,
    input  wire       rst_n,
    input  wire       ce,
    // Serial stream
    input  wire       bit_strobe,
    input  wire       frame_start,
    input  wire       ser_data,
    // Slot select
    input  wire [4:0] slot_sel,
    // Captured byte
    output reg  [7:0] snap_q
);

    reg  [7:0] pos_q;
    reg  [6:0] shift_q;
    wire [7:0] pos_cur;
    wire       last_bit;

    // Frame start marks bit 1 of slot 0
    assign pos_cur  = frame_start ? 8'h00 : pos_q;
    assign last_bit = (pos_cur[7:3] == slot_sel) &&
                      (pos_cur[2:0] == `EFM_FRAME_BITS_LAST);

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pos_q   <= 8'h00;
            shift_q <= 7'h00;
            snap_q  <= 8'h00;
        end else if (ce && bit_strobe) begin
            pos_q   <= pos_cur + 8'h01;
            shift_q <= {shift_q[5:0], ser_data};
            if (last_bit) begin
                snap_q <= {shift_q, ser_data};
            end
        end
    end

endmodule // efm_slot_tap

`default_nettype wire

// file: verification/efm_monitor_props.sv
`timescale 1ns/1ps
`default_nettype none
module efm_monitor_props (
    // Clock, reset, enable
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        ce,
    // Bus
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic        s_axi_rvalid, s_axi_rready,
    input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    // Shared counter bits
    input wire logic [1:0]  crc4_count_msbs, ebit_count_msbs
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Read address taken
    sequence ar_hs;
        ce && s_axi_arvalid && s_axi_arready;
    endsequence
    // Address and data taken together
    sequence wr_hs;
        ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    AST_R_ANS: assert property (ar_hs |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer missing");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    AST_B_ANS: assert property (wr_hs |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    AST_R_HI: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_CRC_BITS: assert property (ar_hs ##0 s_axi_araddr == 12'h008 |=>
        s_axi_rdata[1:0] == $past(crc4_count_msbs)) else $error("upper count low bits");
    AST_EBIT_BITS: assert property (ar_hs ##0 s_axi_araddr == 12'h010 |=>
        s_axi_rdata[1:0] == $past(ebit_count_msbs)) else $error("lower count low bits");
    AST_UNMAP: assert property (ar_hs ##0 s_axi_araddr == 12'h00c |=>
        s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read");
    AST_CE_FREEZE: assert property (!ce |=> $stable(s_axi_awready) && $stable(s_axi_arready)
        && $stable(s_axi_bvalid) && $stable(s_axi_rvalid)) else $error("state moved while frozen");
endmodule // efm_monitor_props
bind efm_monitor efm_monitor_props u_efm_monitor_props (.clock(clock), .rst_n(rst_n), .ce(ce),
    .s_axi_araddr(s_axi_araddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
    .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata),
    .crc4_count_msbs(crc4_count_msbs), .ebit_count_msbs(ebit_count_msbs));
`default_nettype wire

// file: verification/efm_monitor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module efm_monitor_tb_top;
    logic        clock, rst_n, ce;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, crc4_count_msbs, ebit_count_msbs;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        fas_error_pulse, receive_sync_lost, align_search;
    logic        tx_bit_strobe, tx_frame_start, tx_ser_data;
    logic        rx_bit_strobe, rx_frame_start, rx_ser_data;
    int          errors, checked, cnt;

    efm_monitor #(.FAST_CYCLES(22'd300)) u_efm_monitor (.clock(clock), .rst_n(rst_n), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .fas_error_pulse(fas_error_pulse), .receive_sync_lost(receive_sync_lost),
        .align_search(align_search), .crc4_count_msbs(crc4_count_msbs),
        .ebit_count_msbs(ebit_count_msbs), .tx_bit_strobe(tx_bit_strobe),
        .tx_frame_start(tx_frame_start), .tx_ser_data(tx_ser_data),
        .rx_bit_strobe(rx_bit_strobe), .rx_frame_start(rx_frame_start),
        .rx_ser_data(rx_ser_data));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic end_sim();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er);
        int n;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        if (n >= 50) errors++;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd(input logic [11:0] a);
        int n;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        d = s_axi_rdata;
        chk("rresp", 32'h0, {30'h0, s_axi_rresp ^ (a == 12'h00c ? 2'b10 : 2'b00)});
        s_axi_rready <= 1'b0;
        if (n >= 50) errors++;
    endtask

    task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
        rd(a);
        chk(nm, e, d);
    endtask

    function automatic logic [7:0] pat(input int s, input logic [7:0] k);
        return 8'(s * 37) ^ k;
    endfunction

    // One frame on both streams, one strobe every other cycle
    task automatic frame(input logic [7:0] k);
        logic [7:0] t, u;
        for (int s = 0; s < 32; s++) begin
            t = pat(s, k);
            u = pat(s, ~k);
            for (int b = 0; b < 8; b++) begin
                @(posedge clock);
                tx_bit_strobe <= 1'b1;
                rx_bit_strobe <= 1'b1;
                tx_frame_start <= (s == 0 && b == 0);
                rx_frame_start <= (s == 0 && b == 0);
                tx_ser_data <= t[7 - b];
                rx_ser_data <= u[7 - b];
                @(posedge clock);
                tx_bit_strobe <= 1'b0;
                rx_bit_strobe <= 1'b0;
            end
        end
        repeat (2) @(posedge clock);
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        end_sim();
    end

    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, fas_error_pulse} = '0;
        {receive_sync_lost, align_search, tx_bit_strobe, tx_frame_start, tx_ser_data} = '0;
        {rx_bit_strobe, rx_frame_start, rx_ser_data, errors, checked, cnt} = '0;
        s_axi_wstrb = 4'hf;
        crc4_count_msbs = 2'b10;
        ebit_count_msbs = 2'b01;
        ce = 1'b1;
        d = '0;
        rst_n = 1'b0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        rc("txctl", 12'h2a0, 32'h0);
        rc("rxctl", 12'h2a8, 32'h0);
        rc("unmap", 12'h00c, 32'h0);
        wr(12'h00c, 8'h55, 2'b10);
        // Last and first slot, then channels 6 and 15 in slots 5 and 14
        for (int i = 0; i < 2; i++) begin
            wr(12'h2a0, i ? 8'h05 : 8'hff, 2'b00);
            wr(12'h2a8, i ? 8'h0e : 8'he0, 2'b00);
            rc("txctl", 12'h2a0, i ? 32'h05 : 32'hff);
            rc("rxctl", 12'h2a8, i ? 32'h0e : 32'he0);
            frame(i ? 8'h3c : 8'ha5);
            rc("txsnap", 12'h2a4, {24'h0, pat(i ? 5 : 31, i ? 8'h3c : 8'ha5)});
            rc("rxsnap", 12'h2ac, {24'h0, pat(i ? 14 : 0, i ? 8'hc3 : 8'h5a)});
        end
        wr(12'h2a4, 8'h00, 2'b00);
        rc("txsnap", 12'h2a4, {24'h0, pat(5, 8'h3c)});
        wr(12'h2b0, 8'h01, 2'b00);
        rc("intctl", 12'h2b0, 32'h01);
        @(posedge clock);
        fas_error_pulse <= 1'b1;
        @(posedge clock);
        fas_error_pulse <= 1'b0;
        for (int i = 0; i < 200 && d[7:2] !== 6'h01; i++) rd(12'h010);
        chk("errsync", 32'h05, d);
        // Sync loss, alignment search and a low clock enable each block a pulse
        for (int i = 0; i < 100; i++) begin
            @(posedge clock);
            fas_error_pulse <= 1'b1;
            receive_sync_lost <= (i % 10 == 3);
            align_search <= (i % 10 == 7);
            ce <= (i % 10 != 5);
            cnt += (i % 10 != 3 && i % 10 != 7 && i % 10 != 5);
            @(posedge clock);
            fas_error_pulse <= 1'b0;
            receive_sync_lost <= 1'b0;
            align_search <= 1'b0;
            ce <= 1'b1;
        end
        crc4_count_msbs <= 2'b01;
        ebit_count_msbs <= 2'b10;
        repeat (150) @(posedge clock);
        rc("errhi", 12'h008, {24'h0, 6'(cnt >> 6), 2'b01});
        rc("errlo", 12'h010, {24'h0, 6'(cnt), 2'b10});
        repeat (300) @(posedge clock);
        rc("errlo", 12'h010, 32'h02);
        // One-second mode: fast ticks must not update the shown count
        wr(12'h2b0, 8'h00, 2'b00);
        repeat (3) begin
            @(posedge clock);
            fas_error_pulse <= 1'b1;
            @(posedge clock);
            fas_error_pulse <= 1'b0;
        end
        for (int i = 0; i < 1500 && d[7:2] !== 6'h03; i++) rd(12'h010);
        chk("errsec", 32'h0e, d);
        @(posedge clock);
        fas_error_pulse <= 1'b1;
        @(posedge clock);
        fas_error_pulse <= 1'b0;
        repeat (400) @(posedge clock);
        rc("errsec", 12'h010, 32'h0e);
        end_sim();
    end
endmodule // efm_monitor_tb_top
`default_nettype wire
